//--- core/ssfc_consts.svh
`ifndef SSFC_CONSTS_SVH
`define SSFC_CONSTS_SVH

// ****************************************
// control byte fields
// ****************************************
`define SSFC_CR_IRQ_EN 7
`define SSFC_CR_PORT_EN 6
`define SSFC_CR_DIV_EN 5
`define SSFC_CR_MASTER 4
`define SSFC_CR_IDLE_LVL 3
`define SSFC_CR_PHASE 2
`define SSFC_CR_RATE_HI 1
`define SSFC_CR_RATE_LO 0
`define SSFC_CR_RST 8'h00

// ****************************************
// status byte fields
// ****************************************
`define SSFC_SR_DONE 7
`define SSFC_SR_WRITE_COLLISION_FLAG 6
`define SSFC_SR_MODE_FAULT_FLAG 4
`define SSFC_SR_RST 8'h00

// ****************************************
// transfer and crossing
// ****************************************
`define SSFC_LAST_BIT 3'h7
`define SSFC_SYNC_RST 3'h1

`endif

//--- core/ssfc_pkg.sv
package ssfc_pkg;
   typedef logic [7:0] ssfc_byte_t;
   typedef logic [2:0] ssfc_bit_t;
endpackage

//--- core/ssfc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssfc_consts.svh"

module ssfc_core import ssfc_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_ss_n,
   input wire logic i_dr_wr,
   input wire logic [7:0] i_dr_wdata,
   input wire logic i_dr_rd,
   input wire logic i_sr_rd,
   input wire logic i_sr_wr,
   input wire logic i_cr_wr,
   input wire logic [7:0] i_cr_wdata,
   input wire logic i_cpu_imask,
   input wire logic i_mst_shifting,
   input wire logic i_wait,
   input wire logic i_halt,
   output logic [7:0] o_dr_rdata,
   output logic [7:0] o_sr,
   output logic [7:0] o_cr,
   output logic o_irq,
   output logic o_wake,
   output logic o_miso,
   output logic o_miso_oe
);

   // ****************************************
   // cpu-side state
   // ****************************************
   ssfc_byte_t cr;
   ssfc_byte_t tx_byte;
   ssfc_byte_t rx_hold;
   logic xfer_done_flag;
   logic write_collision_flag;
   logic mode_fault_flag;
   logic done_arm;
   logic write_collision_flag_arm;
   logic mode_fault_flag_arm;
   logic irq;
   logic wake;

   logic port_enable;
   logic master_role_bit;
   logic clock_capture_phase;
   logic clock_idle_level;
   logic slave_on;

   assign port_enable = cr[`SSFC_CR_PORT_EN];
   assign master_role_bit = cr[`SSFC_CR_MASTER];
   assign clock_capture_phase = cr[`SSFC_CR_PHASE];
   assign clock_idle_level = cr[`SSFC_CR_IDLE_LVL];
   assign slave_on = port_enable & ~master_role_bit;

   // ****************************************
   // link-side state
   // ****************************************
   logic sclk;
   logic lrst;
   ssfc_bit_t cnt;
   ssfc_bit_t ncnt;
   ssfc_byte_t rx_shift;
   ssfc_byte_t rx_buf;
   logic done_tgl;
   logic mid;
   logic launched;
   logic miso_q;

   // sampling edge becomes rising edge of sclk in all four modes
   assign sclk = i_sck ^ (clock_idle_level ^ clock_capture_phase);
   // link logic idles while deselected, so a half byte never leaks on
   assign lrst = i_rst | i_ss_n | ~slave_on | i_halt;

   function automatic ssfc_bit_t out_index(input logic ph, input ssfc_bit_t n);
      out_index = ph ? (`SSFC_LAST_BIT - n) : (`SSFC_LAST_BIT - n - 3'h1);
   endfunction

   // ****************************************
   // link: sample edge
   // ****************************************
   always_ff @(posedge sclk or posedge lrst) begin
      if (lrst) begin
         cnt <= 3'h0;
         rx_shift <= 8'h00;
         mid <= 1'b0;
      end else begin
         rx_shift <= {rx_shift[6:0], i_mosi};
         cnt <= cnt + 3'h1;
         mid <= (cnt != `SSFC_LAST_BIT);
      end
   end

   // received byte survives deselect, so only the main reset clears it
   always_ff @(posedge sclk or posedge i_rst) begin
      if (i_rst) begin
         rx_buf <= 8'h00;
         done_tgl <= 1'b0;
      end else if (!lrst && cnt == `SSFC_LAST_BIT) begin
         rx_buf <= {rx_shift[6:0], i_mosi};
         done_tgl <= ~done_tgl;
      end
   end

   // ****************************************
   // link: launch edge
   // ****************************************
   always_ff @(negedge sclk or posedge lrst) begin
      if (lrst) begin
         ncnt <= 3'h0;
         launched <= 1'b0;
         miso_q <= 1'b0;
      end else begin
         // tx_byte is frozen while selected in phase zero and only mid-byte in phase one, so reading it here is safe
         miso_q <= tx_byte[out_index(clock_capture_phase, ncnt)];
         ncnt <= ncnt + 3'h1;
         launched <= 1'b1;
      end
   end

   // phase zero shows the msb as soon as selected, phase one waits an edge
   assign o_miso = (~clock_capture_phase & ~launched) ? tx_byte[7] : miso_q;
   assign o_miso_oe = slave_on & ~i_ss_n & (~clock_capture_phase | launched);

   // ****************************************
   // crossing into cpu clock
   // ****************************************
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] filt;
   logic tgl_seen;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1 <= `SSFC_SYNC_RST;
         s2 <= `SSFC_SYNC_RST;
         s3 <= `SSFC_SYNC_RST;
      end else begin
         s1 <= {mid, done_tgl, i_ss_n};
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         filt <= `SSFC_SYNC_RST;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (s2[i] == s3[i]) begin
               filt[i] <= s3[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tgl_seen <= 1'b0;
      end else begin
         tgl_seen <= filt[1];
      end
   end

   // ****************************************
   // cpu-side decode
   // ****************************************
   logic ss_lo;
   logic done_ev;
   logic slave_busy;
   logic collide;
   logic dr_load;
   logic fault;
   logic sr_access;
   ssfc_byte_t next_cr;
   logic next_irq;

   assign ss_lo = ~filt[0];
   assign done_ev = (filt[1] ^ tgl_seen) & ~i_halt;
   assign sr_access = (i_sr_rd | i_sr_wr) & ~i_halt;
   // phase one lets select stay low across bytes, so only mid-byte collides
   assign slave_busy = slave_on & ss_lo & (~clock_capture_phase | filt[2]);
   assign collide = i_dr_wr & ~i_halt
      & (slave_busy | (master_role_bit & i_mst_shifting));
   assign dr_load = i_dr_wr & ~i_halt & ~collide & ~(xfer_done_flag & ~done_arm);
   assign fault = master_role_bit & port_enable & ss_lo & ~i_halt;

   always_comb begin
      next_cr = i_cr_wdata;
      if (mode_fault_flag && !mode_fault_flag_arm) begin
         next_cr[`SSFC_CR_PORT_EN] = 1'b0;
         next_cr[`SSFC_CR_MASTER] = 1'b0;
      end
   end

   // ****************************************
   // control byte
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cr <= `SSFC_CR_RST;
      end else if (fault) begin
         cr[`SSFC_CR_PORT_EN] <= 1'b0;
         cr[`SSFC_CR_MASTER] <= 1'b0;
      end else if (i_cr_wr && !i_halt) begin
         cr <= next_cr;
      end
   end

   // ****************************************
   // data byte paths
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_byte <= 8'h00;
      end else if (dr_load) begin
         tx_byte <= i_dr_wdata;
      end
   end

   // later bytes are dropped while the flag stands, no overrun flag exists
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_hold <= 8'h00;
      end else if (done_ev && !xfer_done_flag) begin
         rx_hold <= rx_buf;
      end
   end

   // ****************************************
   // done flag
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         xfer_done_flag <= 1'b0;
         done_arm <= 1'b0;
      end else if (done_ev) begin
         xfer_done_flag <= 1'b1;
         done_arm <= done_arm & xfer_done_flag;
      end else if (xfer_done_flag && done_arm && i_dr_rd && !i_halt) begin
         xfer_done_flag <= 1'b0;
         done_arm <= 1'b0;
      end else if (xfer_done_flag && sr_access) begin
         done_arm <= 1'b1;
      end
   end

   // ****************************************
   // collision flag
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         write_collision_flag <= 1'b0;
         write_collision_flag_arm <= 1'b0;
      end else if (collide) begin
         write_collision_flag <= 1'b1;
      end else if (write_collision_flag && write_collision_flag_arm && i_dr_rd && !i_halt) begin
         write_collision_flag <= 1'b0;
         write_collision_flag_arm <= 1'b0;
      end else if (write_collision_flag && i_sr_rd && !i_halt) begin
         write_collision_flag_arm <= 1'b1;
      end
   end

   // ****************************************
   // mode fault flag
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_fault_flag <= 1'b0;
         mode_fault_flag_arm <= 1'b0;
      end else if (fault) begin
         mode_fault_flag <= 1'b1;
         mode_fault_flag_arm <= 1'b0;
      end else if (mode_fault_flag && mode_fault_flag_arm && i_cr_wr && !i_halt) begin
         mode_fault_flag <= 1'b0;
         mode_fault_flag_arm <= 1'b0;
      end else if (mode_fault_flag && sr_access) begin
         mode_fault_flag_arm <= 1'b1;
      end
   end

   // ****************************************
   // interrupt and wake
   // ****************************************
   // collision is status only and never reaches the request
   assign next_irq = cr[`SSFC_CR_IRQ_EN] & (xfer_done_flag | mode_fault_flag) & ~i_cpu_imask;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq <= 1'b0;
         wake <= 1'b0;
      end else if (!i_halt) begin
         irq <= next_irq;
         wake <= next_irq & i_wait;
      end else begin
         wake <= 1'b0;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_irq = irq;
   assign o_wake = wake;
   assign o_cr = cr;
   assign o_dr_rdata = rx_hold;
   always_comb begin
      o_sr = `SSFC_SR_RST;
      o_sr[`SSFC_SR_DONE] = xfer_done_flag;
      o_sr[`SSFC_SR_WRITE_COLLISION_FLAG] = write_collision_flag;
      o_sr[`SSFC_SR_MODE_FAULT_FLAG] = mode_fault_flag;
   end

endmodule
`default_nettype wire

//--- test/ssfc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ssfc_checker (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ss_n,
   input wire logic i_dr_wr,
   input wire logic i_dr_rd,
   input wire logic i_sr_rd,
   input wire logic i_sr_wr,
   input wire logic i_cr_wr,
   input wire logic [7:0] i_cr_wdata,
   input wire logic i_cpu_imask,
   input wire logic [7:0] o_sr,
   input wire logic [7:0] o_cr,
   input wire logic o_irq,
   input wire logic o_miso_oe
);
   // ****************
   // clearing sequences armed by a status access
   // ****************
   logic done_arm;
   logic fault_arm;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) done_arm <= 1'b0;
      else if (!o_sr[7]) done_arm <= 1'b0;
      else if (i_sr_rd || i_sr_wr) done_arm <= 1'b1;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) fault_arm <= 1'b0;
      else if (!o_sr[4]) fault_arm <= 1'b0;
      else if (i_sr_rd || i_sr_wr) fault_arm <= 1'b1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // six samples low, so the synchronised select is surely seen
   sequence s_sel; !i_ss_n [*6]; endsequence
   sequence s_slave_wr; i_dr_wr && o_cr[6] && !o_cr[4] && !o_cr[2] && !o_sr[7]; endsequence
   property p_irq_cause; o_irq |-> $past(o_cr[7] && (o_sr[7] || o_sr[4]) && !i_cpu_imask); endproperty
   property p_irq_rise; o_cr[7] && o_sr[7] && !i_cpu_imask |=> o_irq; endproperty
   property p_fault; o_cr[4] && o_cr[6] && $fell(i_ss_n) |-> ##[1:8] (o_sr[4] && !o_cr[6] && !o_cr[4]); endproperty
   property p_fault_hold; o_sr[4] && !fault_arm && i_cr_wr |=> !o_cr[6] && !o_cr[4]; endproperty
   property p_fault_clr; o_sr[4] && fault_arm && i_cr_wr && !i_cr_wdata[4] |=> !o_sr[4]; endproperty
   property p_done_clr; o_sr[7] && done_arm && i_dr_rd |=> !o_sr[7]; endproperty
   property p_write_collision_flag_keep; o_sr[6] && i_dr_wr |=> o_sr[6]; endproperty
   property p_collide; s_sel ##0 s_slave_wr |=> o_sr[6]; endproperty
   property p_oe_ph1; $fell(i_ss_n) && o_cr[2] |-> !o_miso_oe; endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
   a_irq_rise: assert property (p_irq_rise) else $error("irq missing");
   a_fault: assert property (p_fault) else $error("fault not taken");
   a_fault_hold: assert property (p_fault_hold) else $error("enable set in fault");
   a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared");
   a_done_clr: assert property (p_done_clr) else $error("done not cleared");
   a_write_collision_flag_keep: assert property (p_write_collision_flag_keep) else $error("collision lost");
   a_collide: assert property (p_collide) else $error("collision missed");
   a_oe_ph1: assert property (p_oe_ph1) else $error("miso driven early");
endmodule
bind ssfc_core ssfc_checker i_chk (.i_clk, .i_rst, .i_ss_n, .i_dr_wr, .i_dr_rd, .i_sr_rd, .i_sr_wr,
   .i_cr_wr, .i_cr_wdata, .i_cpu_imask, .o_sr, .o_cr, .o_irq, .o_miso_oe);
`default_nettype wire

//--- test/ssfc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssfc_master_model (
   input wire logic i_miso,
   output logic o_sck,
   output logic o_mosi,
   output logic o_ss_n
);
   // ****************
   // far-side master, clock runs only inside frames
   // ****************
   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b1;
      o_ss_n = 1'b1;
   end
   task automatic xfer(input logic [7:0] tx, input logic [1:0] m, output logic [7:0] rx);
      o_sck = m[1];
      #40 o_ss_n = 1'b0;
      #80;
      for (int i = 7; i >= 0; i--) begin
         if (!m[0]) o_mosi = tx[i];
         #40;
         if (!m[0]) rx[i] = i_miso;
         o_sck = !m[1];
         if (m[0]) o_mosi = tx[i];
         #40;
         if (m[0]) rx[i] = i_miso;
         o_sck = m[1];
      end
      #40 o_ss_n = 1'b1;
      // released line must not keep its last bit
      o_mosi = !o_mosi;
      #80;
   endtask
   task automatic fault_pulse();
      o_ss_n = 1'b0;
      #400 o_ss_n = 1'b1;
   endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import ssfc_pkg::*;;
   // ****************
   // stimulus and checks
   // ****************
   localparam int DW = 0, DR = 1, SR = 2, CW = 3, SW = 4;
   logic i_clk, i_rst, i_sck, i_mosi, i_ss_n, i_dr_wr, i_dr_rd, i_sr_rd, i_cr_wr;
   logic i_sr_wr, i_cpu_imask, i_mst_shifting, i_wait, i_halt, o_irq, o_wake, o_miso, o_miso_oe;
   ssfc_byte_t i_dr_wdata, i_cr_wdata, o_dr_rdata, o_sr, o_cr, rx;
   ssfc_byte_t tx_tbl [5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h5A};
   int fail_count = 0, compares = 0, cycles = 0;
   ssfc_core i_dut (.i_clk, .i_rst, .i_sck, .i_mosi, .i_ss_n, .i_dr_wr, .i_dr_wdata, .i_dr_rd,
      .i_sr_rd, .i_sr_wr, .i_cr_wr, .i_cr_wdata, .i_cpu_imask, .i_mst_shifting, .i_wait, .i_halt,
      .o_dr_rdata, .o_sr, .o_cr, .o_irq, .o_wake, .o_miso, .o_miso_oe);
   ssfc_master_model i_mst (.i_miso(o_miso), .o_sck(i_sck), .o_mosi(i_mosi), .o_ss_n(i_ss_n));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic give_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input ssfc_byte_t got, input ssfc_byte_t exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input int k, input ssfc_byte_t d);
      @(posedge i_clk);
      i_dr_wdata <= d;
      i_cr_wdata <= d;
      case (k)
         DW: i_dr_wr <= 1'b1;
         DR: i_dr_rd <= 1'b1;
         SR: i_sr_rd <= 1'b1;
         SW: i_sr_wr <= 1'b1;
         default: i_cr_wr <= 1'b1;
      endcase
      @(posedge i_clk);
      {i_dr_wr, i_dr_rd, i_sr_rd, i_sr_wr, i_cr_wr} <= 5'h00;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   // bounded wait on a status bit, then let the irq register follow
   task automatic wait_flag(input int b);
      for (int n = 0; n < 40 && o_sr[b] !== 1'b1; n++) @(posedge i_clk);
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   initial begin
      {i_dr_wr, i_dr_rd, i_sr_rd, i_sr_wr, i_cr_wr, i_cpu_imask, i_mst_shifting, i_wait, i_halt} = '0;
      i_dr_wdata = 8'h00;
      i_cr_wdata = 8'h00;
      i_rst = 1'b1;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      chk(o_sr, 8'h00);
      chk(o_cr, 8'h00);
      $display("test reset done");
      acc(CW, 8'hC0);
      acc(DW, tx_tbl[0]);
      for (int m = 0; m < 4; m++) begin
         acc(CW, 8'hC0 | ssfc_byte_t'(m << 2));
         i_mst.xfer(8'h90 | ssfc_byte_t'(m), m[1:0], rx);
         wait_flag(7);
         chk(rx, tx_tbl[m]);
         chk(o_dr_rdata, 8'h90 | ssfc_byte_t'(m));
         chk(o_sr, 8'h80);
         chk({7'h00, o_irq}, 8'h01);
         acc(DW, 8'hEE);
         acc(SR, 8'h00);
         acc(DW, tx_tbl[m + 1]);
         acc(DR, 8'h00);
         chk(o_sr, 8'h00);
      end
      $display("test modes done");
      acc(CW, 8'hC0);
      fork
         i_mst.xfer(8'h66, 2'b00, rx);
         begin
            repeat (12) @(posedge i_clk);
            acc(DW, 8'hFF);
         end
      join
      wait_flag(7);
      chk(o_sr, 8'hC0);
      chk(rx, tx_tbl[4]);
      chk(o_dr_rdata, 8'h66);
      acc(SR, 8'h00);
      acc(DW, 8'h11);
      chk(o_sr & 8'h40, 8'h40);
      acc(DR, 8'h00);
      chk(o_sr, 8'h00);
      $display("test collision done");
      i_mst.xfer(8'h12, 2'b00, rx);
      wait_flag(7);
      chk(rx, 8'h11);
      acc(DW, 8'h22);
      i_mst.xfer(8'h34, 2'b00, rx);
      wait_flag(7);
      // let a late second byte reach the buffer if it wrongly could
      repeat (4) @(posedge i_clk);
      #1;
      chk(rx, 8'h11);
      chk(o_dr_rdata, 8'h12);
      chk(o_sr, 8'h80);
      acc(SR, 8'h00);
      acc(DR, 8'h00);
      $display("test overrun done");
      acc(CW, 8'hD0);
      i_mst.fault_pulse();
      wait_flag(4);
      chk(o_sr, 8'h10);
      chk(o_cr, 8'h80);
      chk({7'h00, o_irq}, 8'h01);
      @(posedge i_clk) i_wait <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 chk({7'h00, o_wake}, 8'h01);
      @(posedge i_clk) i_cpu_imask <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1 chk({7'h00, o_irq}, 8'h00);
      chk({7'h00, o_wake}, 8'h00);
      @(posedge i_clk) {i_cpu_imask, i_wait} <= 2'b00;
      acc(CW, 8'hD0);
      chk(o_cr, 8'h80);
      chk(o_sr, 8'h10);
      acc(SW, 8'h00);
      acc(CW, 8'hC0);
      chk(o_sr, 8'h00);
      chk(o_cr, 8'hC0);
      $display("test fault done");
      acc(CW, 8'hD0);
      @(posedge i_clk) i_mst_shifting <= 1'b1;
      acc(DW, 8'h55);
      chk(o_sr, 8'h40);
      @(posedge i_clk) i_mst_shifting <= 1'b0;
      acc(SR, 8'h00);
      acc(DR, 8'h00);
      chk(o_sr, 8'h00);
      $display("test master collision done");
      @(posedge i_clk) i_halt <= 1'b1;
      acc(CW, 8'h00);
      chk(o_cr, 8'hD0);
      chk({7'h00, o_wake}, 8'h00);
      @(posedge i_clk) i_halt <= 1'b0;
      $display("test low power done");
      give_verdict();
   end
endmodule
`default_nettype wire
